// ---- rtl/udl_pkg.sv ----
package udl_pkg;

   // Word width of preset, thresholds and count
   localparam int VAL_W = 16;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int IRQ_W = 3;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PRESET = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_MIN = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_MAX = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_CURRENT = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_HISTORY = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h24;

   // Field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int FLAG_LO_BIT = 0;
   localparam int FLAG_HI_BIT = 1;
   localparam int HIST_UP_BIT = 0;
   localparam int HIST_DN_BIT = 1;
   localparam int IRQ_LO_BIT = 0;
   localparam int IRQ_HI_BIT = 1;
   localparam int IRQ_WRAP_BIT = 2;

   // Values after reset, and fixed word constants
   localparam logic [VAL_W-1:0] RST_PRESET = 16'h0000;
   localparam logic [VAL_W-1:0] RST_MIN = 16'h0000;
   localparam logic [VAL_W-1:0] RST_MAX = 16'h0001;
   localparam logic [VAL_W-1:0] VAL_ONE = 16'h0001;
   localparam logic [VAL_W-1:0] VAL_ZERO = 16'h0000;
   localparam logic [VAL_W-1:0] VAL_POS_TOP = 16'h7fff;
   localparam logic [VAL_W-1:0] VAL_NEG_TOP = 16'h8000;

   // Limit flags as one carrier
   typedef struct packed {
      logic hi;
      logic lo;
   } udl_flags_t;

   // Whole state of the counter block
   typedef struct packed {
      logic up_s1;
      logic up_s2;
      logic dn_s1;
      logic dn_s2;
      logic enable;
      logic [VAL_W-1:0] preset;
      logic [VAL_W-1:0] min_thr;
      logic [VAL_W-1:0] max_thr;
      logic [VAL_W-1:0] cur;
      udl_flags_t flags;
      logic [VAL_W-1:0] hist;
      logic [IRQ_W-1:0] irq_st;
      logic [IRQ_W-1:0] irq_en;
      logic [DATA_W-1:0] rdata;
   } udl_state_t;

endpackage

// ---- rtl/udl_counter.sv ----
// Behaviour
// - Count and limit flags follow the count inputs only while the enable bit is 1.
// - Up edges raise and down edges lower the count; both in one cycle cancel.
// - The count starts from the preset and is shown as current value.
// - A 16-bit history word keeps up in bit 0 and down in bit 1.
// - While disabled each cycle clears flags and history, loads preset.
// - With max above min, high at or over max, low at or under min.
// - With max not above min, low below max and high otherwise.
// - Preset changes while enabled are ignored until a disabled reload.
// - A negative preset or minimum is used as zero.
// - A maximum below one is used as one.
module udl_counter
   import udl_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [udl_pkg::ADDR_W-1:0] paddr,
   input wire logic [udl_pkg::DATA_W-1:0] pwdata,
   output logic [udl_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic count_up_input,
   input wire logic count_down_input,
   output logic [udl_pkg::VAL_W-1:0] current_value,
   output udl_pkg::udl_flags_t limit_flags,
   output logic irq
);
   import udl_pkg::*;

   udl_state_t s_r;
   udl_state_t s_nxt;

   logic acc;
   logic wr;
   logic up_rise;
   logic dn_rise;
   logic wrap_ev;
   logic [VAL_W-1:0] pre_c;
   logic [VAL_W-1:0] min_c;
   logic [VAL_W-1:0] max_c;
   logic [IRQ_W-1:0] ev;
   logic [IRQ_W-1:0] clr;

   // Negative word read as zero
   function automatic logic [VAL_W-1:0] clamp_zero(logic [VAL_W-1:0] v);
      return v[VAL_W-1] ? VAL_ZERO : v;
   endfunction

   // Word below one read as one
   function automatic logic [VAL_W-1:0] clamp_one(logic [VAL_W-1:0] v);
      return ($signed(v) < $signed(VAL_ONE)) ? VAL_ONE : v;
   endfunction

   // Signed a >= b
   function automatic logic sge(logic [VAL_W-1:0] a, logic [VAL_W-1:0] b);
      return $signed(a) >= $signed(b);
   endfunction

   // Address decode for the error answer; the read mux decodes on its own
   function automatic logic is_mapped(logic [ADDR_W-1:0] a);
      unique case (a)
         OFS_CTRL, OFS_PRESET, OFS_MIN, OFS_MAX, OFS_CURRENT, OFS_FLAGS,
         OFS_HISTORY, OFS_IRQ_STATUS, OFS_IRQ_CLEAR,
         OFS_IRQ_ENABLE: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // Limit flags from a count and the clamped thresholds
   function automatic udl_flags_t limits(logic [VAL_W-1:0] c,
                                         logic [VAL_W-1:0] mn,
                                         logic [VAL_W-1:0] mx);
      udl_flags_t f;
      f = '0;
      if (!sge(mn, mx)) begin
         f.hi = sge(c, mx);
         f.lo = sge(mn, c);
      end else begin
         f.lo = !sge(c, mx);
         f.hi = sge(c, mx);
      end
      return f;
   endfunction

   // Zero wait states; error only for unmapped addresses
   assign pready = 1'b1;
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign pslverr = acc && !is_mapped(paddr);

   // Outputs straight from the state register
   assign prdata = s_r.rdata;
   assign current_value = s_r.cur;
   assign limit_flags = s_r.flags;
   assign irq = |(s_r.irq_st & s_r.irq_en);

   // Clamped operands, taken fresh each evaluation
   assign pre_c = clamp_zero(s_r.preset);
   assign min_c = clamp_zero(s_r.min_thr);
   assign max_c = clamp_one(s_r.max_thr);

   // Edge detect against the stored history, not the raw pin
   assign up_rise = s_r.enable && s_r.up_s2 && !s_r.hist[HIST_UP_BIT];
   assign dn_rise = s_r.enable && s_r.dn_s2 && !s_r.hist[HIST_DN_BIT];

   // Wrap of the signed count raises an event rather than saturating
   assign wrap_ev = (up_rise && !dn_rise && s_r.cur == VAL_POS_TOP) ||
                    (dn_rise && !up_rise && s_r.cur == VAL_NEG_TOP);

   assign clr = (wr && paddr == OFS_IRQ_CLEAR) ? pwdata[IRQ_W-1:0] : '0;

   // Next state: sync, count, flags, registers, interrupts
   always_comb begin
      s_nxt = s_r;
      // Pins pass two flops before any logic reads them
      s_nxt.up_s1 = count_up_input;
      s_nxt.up_s2 = s_r.up_s1;
      s_nxt.dn_s1 = count_down_input;
      s_nxt.dn_s2 = s_r.dn_s1;

      if (!s_r.enable) begin
         // Reload each cycle from the stored preset, so a preset written now lands a cycle later
         s_nxt.cur = pre_c;
         s_nxt.flags = '0;
         s_nxt.hist[HIST_UP_BIT] = 1'b0;
         s_nxt.hist[HIST_DN_BIT] = 1'b0;
      end else begin
         // Both edges together cancel out
         if (up_rise && !dn_rise) begin
            s_nxt.cur = s_r.cur + VAL_ONE;
         end else if (dn_rise && !up_rise) begin
            s_nxt.cur = s_r.cur - VAL_ONE;
         end
         s_nxt.hist[HIST_UP_BIT] = s_r.up_s2;
         s_nxt.hist[HIST_DN_BIT] = s_r.dn_s2;
         s_nxt.flags = limits(s_nxt.cur, min_c, max_c);
      end
      s_nxt.hist[VAL_W-1:2] = '0;

      // Register writes take effect in the access cycle
      if (wr) begin
         unique case (paddr)
            OFS_CTRL: s_nxt.enable = pwdata[CTRL_EN_BIT];
            OFS_PRESET: s_nxt.preset = pwdata[VAL_W-1:0];
            OFS_MIN: s_nxt.min_thr = pwdata[VAL_W-1:0];
            OFS_MAX: s_nxt.max_thr = pwdata[VAL_W-1:0];
            OFS_IRQ_ENABLE: s_nxt.irq_en = pwdata[IRQ_W-1:0];
            default: ;
         endcase
      end

      // Sticky events; a set in the clear cycle wins
      ev = '0;
      ev[IRQ_LO_BIT] = s_nxt.flags.lo && !s_r.flags.lo;
      ev[IRQ_HI_BIT] = s_nxt.flags.hi && !s_r.flags.hi;
      ev[IRQ_WRAP_BIT] = wrap_ev;
      s_nxt.irq_st = (s_r.irq_st & ~clr) | ev;

      // Read data captured in the setup cycle, shown in access
      if (psel && !penable && !pwrite) begin
         s_nxt.rdata = '0;
         unique case (paddr)
            OFS_CTRL: s_nxt.rdata[CTRL_EN_BIT] = s_r.enable;
            OFS_PRESET: s_nxt.rdata[VAL_W-1:0] = s_r.preset;
            OFS_MIN: s_nxt.rdata[VAL_W-1:0] = s_r.min_thr;
            OFS_MAX: s_nxt.rdata[VAL_W-1:0] = s_r.max_thr;
            OFS_CURRENT: s_nxt.rdata[VAL_W-1:0] = s_r.cur;
            OFS_FLAGS: s_nxt.rdata[1:0] = {s_r.flags.hi, s_r.flags.lo};
            OFS_HISTORY: s_nxt.rdata[VAL_W-1:0] = s_r.hist;
            OFS_IRQ_STATUS: s_nxt.rdata[IRQ_W-1:0] = s_r.irq_st;
            OFS_IRQ_ENABLE: s_nxt.rdata[IRQ_W-1:0] = s_r.irq_en;
            default: ;
         endcase
      end
   end

   // Single state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.preset <= RST_PRESET;
         s_r.min_thr <= RST_MIN;
         s_r.max_thr <= RST_MAX;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_disabled_reload;
      !s_r.enable |=> current_value == $past(pre_c) &&
         limit_flags == '0 && s_r.hist[1:0] == 2'b00;
   endproperty
   a_disabled_reload: assert property (p_disabled_reload)
      else $error("disabled reload wrong");

   property p_up_step;
      s_r.enable && up_rise && !dn_rise |=>
         current_value == $past(current_value) + VAL_ONE;
   endproperty
   a_up_step: assert property (p_up_step)
      else $error("up edge did not add one");

   property p_down_step;
      s_r.enable && dn_rise && !up_rise |=>
         current_value == $past(current_value) - VAL_ONE;
   endproperty
   a_down_step: assert property (p_down_step)
      else $error("down edge did not take one");

   property p_history;
      s_r.enable |=> s_r.hist[1:0] == {$past(s_r.dn_s2), $past(s_r.up_s2)};
   endproperty
   a_history: assert property (p_history)
      else $error("history bits not stored");

   // Up held high two enabled cycles: history caught it, no second step
   property p_level_no_count;
      s_r.enable && s_r.up_s2 && !s_r.dn_s2 ##1
         s_r.enable && s_r.up_s2 && !s_r.dn_s2 |=> $stable(current_value);
   endproperty
   a_level_no_count: assert property (p_level_no_count)
      else $error("steady input counted");

   property p_window_flags;
      $past(s_r.enable) && !sge($past(min_c), $past(max_c)) |->
         limit_flags.hi == sge(current_value, $past(max_c)) &&
         limit_flags.lo == sge($past(min_c), current_value);
   endproperty
   a_window_flags: assert property (p_window_flags)
      else $error("flags wrong with max above min");

   property p_folded_flags;
      $past(s_r.enable) && sge($past(min_c), $past(max_c)) |->
         limit_flags.lo == !sge(current_value, $past(max_c)) &&
         limit_flags.hi == !limit_flags.lo;
   endproperty
   a_folded_flags: assert property (p_folded_flags)
      else $error("flags wrong with max not above min");

   property p_preset_ignored;
      s_r.enable ##1 s_r.enable && !$past(up_rise) && !$past(dn_rise) |->
         $stable(current_value);
   endproperty
   a_preset_ignored: assert property (p_preset_ignored)
      else $error("count moved without an edge");

   property p_neg_preset;
      !s_r.enable && s_r.preset[VAL_W-1] |=> current_value == VAL_ZERO;
   endproperty
   a_neg_preset: assert property (p_neg_preset)
      else $error("negative preset not zero");

   property p_max_floor;
      s_r.enable && !sge(s_r.max_thr, VAL_ONE) && min_c == VAL_ZERO |=>
         limit_flags.hi == sge(current_value, VAL_ONE);
   endproperty
   a_max_floor: assert property (p_max_floor)
      else $error("small max not taken as one");

   property p_hold_disabled;
      !s_r.enable ##1 !s_r.enable |-> limit_flags == '0 &&
         current_value == $past(pre_c);
   endproperty
   a_hold_disabled: assert property (p_hold_disabled)
      else $error("disabled counter changed");

   property p_level_down;
      s_r.enable && s_r.dn_s2 && !s_r.up_s2 ##1
         s_r.enable && s_r.dn_s2 && !s_r.up_s2 |=> $stable(current_value);
   endproperty
   a_level_down: assert property (p_level_down)
      else $error("steady down input counted");

   property p_flags_exclusive;
      !(limit_flags.hi && limit_flags.lo);
   endproperty
   a_flags_exclusive: assert property (p_flags_exclusive)
      else $error("both limit flags set");

   // Clamped minimum is zero and max at least one, so the window case
   property p_neg_min;
      s_r.enable && s_r.min_thr[VAL_W-1] |=>
         limit_flags.lo == !sge(current_value, VAL_ONE);
   endproperty
   a_neg_min: assert property (p_neg_min)
      else $error("negative minimum not zero");

   // Bus and interrupt side
   property p_lo_event;
      !limit_flags.lo ##1 limit_flags.lo |-> s_r.irq_st[IRQ_LO_BIT];
   endproperty
   a_lo_event: assert property (p_lo_event)
      else $error("low flag rise not recorded");

   property p_hi_event;
      !limit_flags.hi ##1 limit_flags.hi |-> s_r.irq_st[IRQ_HI_BIT];
   endproperty
   a_hi_event: assert property (p_hi_event)
      else $error("high flag rise not recorded");

   // Wrap is reported, never saturated
   property p_wrap_up;
      up_rise && !dn_rise && current_value == VAL_POS_TOP |=>
         current_value == VAL_NEG_TOP && s_r.irq_st[IRQ_WRAP_BIT];
   endproperty
   a_wrap_up: assert property (p_wrap_up)
      else $error("upward wrap wrong");

   property p_wrap_down;
      dn_rise && !up_rise && current_value == VAL_NEG_TOP |=>
         current_value == VAL_POS_TOP && s_r.irq_st[IRQ_WRAP_BIT];
   endproperty
   a_wrap_down: assert property (p_wrap_down)
      else $error("downward wrap wrong");

   property p_irq_out;
      s_r.irq_st[IRQ_HI_BIT] && s_r.irq_en[IRQ_HI_BIT] |-> irq;
   endproperty
   a_irq_out: assert property (p_irq_out)
      else $error("enabled status bit gave no interrupt");

   // Only a clear write may drop a sticky bit
   property p_status_sticky;
      s_r.irq_st[IRQ_LO_BIT] && !clr[IRQ_LO_BIT] |=>
         s_r.irq_st[IRQ_LO_BIT];
   endproperty
   a_status_sticky: assert property (p_status_sticky)
      else $error("status bit lost without clear");

   property p_write_lands;
      psel && penable && pwrite && paddr == OFS_MAX |=>
         s_r.max_thr == $past(pwdata[VAL_W-1:0]);
   endproperty
   a_write_lands: assert property (p_write_lands)
      else $error("threshold write did not land");

   // Read word is the value seen in the setup cycle
   property p_read_data;
      psel && !penable && !pwrite && paddr == OFS_CURRENT |=>
         prdata[VAL_W-1:0] == $past(current_value) &&
         prdata[DATA_W-1:VAL_W] == '0;
   endproperty
   a_read_data: assert property (p_read_data)
      else $error("count read wrong");

endmodule

// ---- dv/udl_pin_model.sv ----
// Stands in for the user program that sets the count pins each scan
module udl_pin_model (
   input wire logic pclk,
   output logic up_pin,
   output logic dn_pin
);
   timeunit 1ns;
   timeprecision 1ns;

   // Both pins idle low, so nothing counts before a call
   initial begin
      up_pin = 1'b0;
      dn_pin = 1'b0;
   end

   // Set both levels after an edge and hold them n cycles; n of 1 or
   // more gives the two sync stages time to see a low between counts
   task automatic drive(input logic u, input logic d, input int n);
      up_pin <= u;
      dn_pin <= d;
      repeat (n) @(posedge pclk);
   endtask
endmodule

// ---- dv/tb_updown_limit_counter.sv ----
module tb_updown_limit_counter import udl_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic up_pin, dn_pin;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd;
   logic [VAL_W-1:0] cur;
   udl_flags_t flg;
   int failures, check_count;
   // Threshold cases: preset, min, max, expected count and flags
   logic [15:0] tp[5] = '{16'h0006, 16'h0002, 16'h0004, 16'h0000, 16'h8000};
   logic [15:0] tn[5] = '{16'h000a, 16'h000a, 16'h0004, 16'hfff0, 16'h0000};
   logic [15:0] tx[5] = '{16'h0004, 16'h0004, 16'h0004, 16'hffff, 16'h0005};
   logic [15:0] tc[5] = '{16'h0006, 16'h0002, 16'h0004, 16'h0000, 16'h0000};
   logic [1:0] tf[5] = '{2'h2, 2'h1, 2'h2, 2'h1, 2'h1};

   udl_counter dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .count_up_input(up_pin), .count_down_input(dn_pin),
      .current_value(cur), .limit_flags(flg), .irq(irq));
   udl_pin_model pm (.pclk(pclk), .up_pin(up_pin), .dn_pin(dn_pin));

   // 25 MHz clock
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic check(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One APB transfer; an idle edge after it keeps drivers single-assigned
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No cycle count assumed; a hang falls to the watchdog
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rchk(input string nm, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] exp);
      apb(1'b0, a, '0);
      check(nm, rd, exp);
   endtask

   task automatic pulses(input logic dn, input int k);
      repeat (k) begin
         pm.drive(!dn, dn, 4);
         pm.drive(1'b0, 1'b0, 4);
      end
   endtask

   task automatic stop_test();
      if (failures == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      stop_test();
   end

   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      presetn = 1'b0;
      failures = 0;
      check_count = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk("max", OFS_MAX, 32'h1);
      rchk("unmapped", 8'h3c, 32'h0);
      check("slverr", err, 1'b1);
      // Count up to max and down to min
      apb(1'b1, OFS_PRESET, 32'h5);
      apb(1'b1, OFS_MIN, 32'h3);
      apb(1'b1, OFS_MAX, 32'h8);
      apb(1'b1, OFS_CTRL, 32'h1);
      @(posedge pclk);
      check("start", cur, 16'h0005);
      check("mid", flg, 2'h0);
      pulses(1'b0, 3);
      check("up", cur, 16'h0008);
      check("at max", flg, 2'h2);
      pm.drive(1'b1, 1'b0, 4);
      rchk("hist up", OFS_HISTORY, 32'h1);
      pm.drive(1'b0, 1'b1, 4);
      rchk("hist dn", OFS_HISTORY, 32'h2);
      pm.drive(1'b0, 1'b0, 4);
      check("one step", cur, 16'h0008);
      pulses(1'b1, 5);
      check("down", cur, 16'h0003);
      check("at min", flg, 2'h1);
      // Flag interrupts: raised, masked, cleared
      rchk("irq st", OFS_IRQ_STATUS, 32'h3);
      check("irq masked", irq, 1'b0);
      apb(1'b1, OFS_IRQ_ENABLE, 32'h2);
      check("irq on", irq, 1'b1);
      apb(1'b1, OFS_IRQ_CLEAR, 32'h2);
      check("irq off", irq, 1'b0);
      // Preset while enabled is ignored until disable
      apb(1'b1, OFS_PRESET, 32'h14);
      pulses(1'b0, 1);
      check("no reload", cur, 16'h0004);
      apb(1'b1, OFS_CTRL, 32'h0);
      @(posedge pclk);
      check("reload", cur, 16'h0014);
      check("off flags", flg, 2'h0);
      rchk("hist clr", OFS_HISTORY, 32'h0);
      pulses(1'b0, 1);
      check("held", cur, 16'h0014);
      // Threshold and clamp cases
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, OFS_PRESET, {16'h0, tp[i]});
         apb(1'b1, OFS_MIN, {16'h0, tn[i]});
         apb(1'b1, OFS_MAX, {16'h0, tx[i]});
         apb(1'b1, OFS_CTRL, 32'h1);
         @(posedge pclk);
         check("case cv", cur, tc[i]);
         check("case flags", flg, tf[i]);
         apb(1'b1, OFS_CTRL, 32'h0);
      end
      // Wrap at the positive top, then back down through it
      apb(1'b1, OFS_PRESET, 32'h7fff);
      apb(1'b1, OFS_CTRL, 32'h1);
      pulses(1'b0, 1);
      check("wrap cv", cur, 16'h8000);
      check("wrap lo", flg, 2'h1);
      rchk("cur rd", OFS_CURRENT, 32'h8000);
      apb(1'b1, OFS_IRQ_CLEAR, 32'h3);
      rchk("wrap st", OFS_IRQ_STATUS, 32'h4);
      pulses(1'b1, 1);
      check("wrap back", cur, 16'h7fff);
      stop_test();
   end
endmodule
